// [hdl/fcs_map.svh]
// Address map, field positions, command codes and timing counts of the flash sequencer
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// Register byte offsets on the AHB-Lite port
`define FCS_DIV_OFF 18'h00000
`define FCS_STAT_OFF 18'h00004
`define FCS_CMD_OFF 18'h00008
// Address bit that selects the array window (one byte per word)
`define FCS_ARRAY_SEL_BIT 17
// Divider register fields
`define FCS_DIV_LD_BIT 7
`define FCS_DIV_PRE_BIT 6
`define FCS_DIV_RESET 6'h00
// Status register fields
`define FCS_ST_CBEF_BIT 7
`define FCS_ST_CCF_BIT 6
`define FCS_ST_ERR_BIT 4
`define FCS_ST_BLANK_BIT 2
// Command codes
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41
// Operation times in timing-clock periods
`define FCS_T_BYTE 15'h0009
`define FCS_T_BURST 15'h0004
`define FCS_T_PAGE 4000
`define FCS_T_MASS 20000
// Array geometry: row and page size as address bit counts
`define FCS_ROW_BITS 6
`define FCS_PAGE_BITS 9
`define FCS_ARRAY_BYTES 8192
`define FCS_ERASED 8'hff
`endif

// [hdl/fcs_pkg.sv]
// Types shared by the flash command sequencer
package fcs_pkg;
   // Host command sequence progress
   typedef enum logic [1:0] {
      FCS_SEQ_IDLE = 2'b00,
      FCS_SEQ_ADDR = 2'b01,
      FCS_SEQ_CMD = 2'b10
   } fcs_seq_e;
   // Executor activity
   typedef enum logic [1:0] {
      FCS_EX_IDLE = 2'b00,
      FCS_EX_PROG = 2'b01,
      FCS_EX_ERASE = 2'b10,
      FCS_EX_BLANK = 2'b11
   } fcs_exec_e;
endpackage : fcs_pkg

// [hdl/fcs_flash_sequencer.sv]
// Flash command sequencer with AHB-Lite registers and the flash array
// What this block does
// (R1) Host sets the divider so the timing clock lies in 150-200 kHz first.
// (R2) Only the first divider write after reset is taken; later ones are ignored.
// (R3) Divider writes are blocked while the access error flag is set.
// (R4) Times: byte 9, burst 4, page erase 4000, mass erase 20000 periods.
// (R5) Each sequence starts with an array write; address and data are captured.
// (R6) Page erase clears the captured page; erase/blank check ignore the data.
// (R7) Codes 0x05 blank check, 0x20 byte, 0x25 burst program are latched.
// (R8) Code 0x40 is page erase, 0x41 mass erase of the whole array.
// (R9) Writing one to the buffer-empty flag clears it and launches the command.
// (R10) Writing zero to buffer-empty mid-sequence abandons it and sets access error.
// (R11) A command-complete flag shows the launched work has fully finished.
// (R12) Pump stays on only for a queued burst byte in the same row.
// (R13) First burst byte and a new row take the single-byte time; pump cycles.
// (R14) No queued burst at byte end turns the pump off.
// (R15) Writing one clears access error; no new command can be started or launched while it is set.
// (R16) Array write before the divider is loaded sets access error.
// (R17) Array write while the buffer is occupied sets access error.
// (R18) A second array or command write before launch sets access error.
// (R19) Wrong register written after array or command write sets access error.
// (R20) Any command code outside the five valid ones sets access error.
// (R21) Stop mode during program or erase aborts it and sets access error.
// (R22) Secured debug path may only blank check or mass erase.
// (R23) Buffer-empty sets again once the executor takes the launched command.
`timescale 1ns/1ps
`include "fcs_map.svh"

module fcs_flash_sequencer #(
   parameter int ARRAY_BYTES = `FCS_ARRAY_BYTES,
   parameter int PAGE_TICKS = `FCS_T_PAGE,
   parameter int MASS_TICKS = `FCS_T_MASS
) (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [17:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // System status inputs
   input wire logic bdm_access,
   input wire logic secured,
   input wire logic stop_req,
   // Array status outputs
   output logic pump_on,
   output logic flash_busy
);
   import fcs_pkg::*;

   localparam int AW = $clog2(ARRAY_BYTES);
   localparam int RB = `FCS_ROW_BITS;
   localparam int PB = `FCS_PAGE_BITS;

   // Valid command codes
   function automatic logic fcs_code_ok(input logic [7:0] c);
      fcs_code_ok = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_BYTE) ||
         (c == `FCS_CMD_BURST) || (c == `FCS_CMD_PAGE) || (c == `FCS_CMD_MASS);
   endfunction : fcs_code_ok

   // Codes that change array contents byte or page wise
   function automatic logic fcs_code_prot(input logic [7:0] c);
      fcs_code_prot = (c == `FCS_CMD_BYTE) || (c == `FCS_CMD_BURST) ||
         (c == `FCS_CMD_PAGE);
   endfunction : fcs_code_prot

   logic [7:0] mem [ARRAY_BYTES];
   logic dp_wr_reg;
   logic dp_bdm_reg;
   logic [17:0] dp_addr_reg;
   logic [31:0] hrdata_reg;
   logic [5:0] div_val_reg;
   logic div_pre_reg;
   logic div_ld_reg;
   logic err_reg;
   logic cbef_reg;
   logic blank_reg;
   fcs_seq_e seq_reg;
   fcs_seq_e seq_next;
   logic [AW-1:0] buf_addr_reg;
   logic [7:0] buf_data_reg;
   logic [7:0] buf_cmd_reg;
   fcs_exec_e ex_reg;
   fcs_exec_e ex_next;
   logic [AW-1:0] ex_addr_reg;
   logic [7:0] ex_data_reg;
   logic ex_burst_reg;
   logic ex_mass_reg;
   logic [14:0] ex_cnt_reg;
   logic [14:0] ex_cnt_next;
   logic [8:0] pre_cnt_reg;
   logic pump_reg;

   // Bus address phase is accepted every enabled cycle; no wait states
   wire addr_take = hsel & hready & htrans[1] & hce;
   wire sel_arr_a = haddr[`FCS_ARRAY_SEL_BIT];
   wire [AW-1:0] idx_a = haddr[AW+1:2];
   wire [7:0] stat_byte = {cbef_reg, (ex_reg == FCS_EX_IDLE) & cbef_reg, 1'b0, err_reg,
      1'b0, blank_reg, 2'b00};
   wire [31:0] rd_word =
      sel_arr_a ? {24'h000000, mem[idx_a]} :
      (haddr == `FCS_DIV_OFF) ? {24'h000000, div_ld_reg, div_pre_reg, div_val_reg} :
      (haddr == `FCS_STAT_OFF) ? {24'h000000, stat_byte} :
      (haddr == `FCS_CMD_OFF) ? {24'h000000, buf_cmd_reg} : 32'h00000000;

   // Data phase write decode
   wire [7:0] wd = hwdata[7:0];
   wire dp_arr = dp_addr_reg[`FCS_ARRAY_SEL_BIT];
   wire [AW-1:0] dp_idx = dp_addr_reg[AW+1:2];
   wire wr_arr = dp_wr_reg & dp_arr;
   wire wr_div = dp_wr_reg & ~dp_arr & (dp_addr_reg == `FCS_DIV_OFF);
   wire wr_stat = dp_wr_reg & ~dp_arr & (dp_addr_reg == `FCS_STAT_OFF);
   wire wr_cmd = dp_wr_reg & ~dp_arr & (dp_addr_reg == `FCS_CMD_OFF);
   wire s_idle = (seq_reg == FCS_SEQ_IDLE);
   wire s_addr = (seq_reg == FCS_SEQ_ADDR);
   wire s_cmd = (seq_reg == FCS_SEQ_CMD);

   // Access error causes; a set flag refuses every sequence write
   wire e_arr = wr_arr & ~err_reg & (~div_ld_reg | ~cbef_reg | ~s_idle); // (R16) (R17) (R18)
   wire start = wr_arr & ~err_reg & div_ld_reg & cbef_reg & s_idle; // (R5) (R15)
   wire cmd_sec = dp_bdm_reg & secured & fcs_code_prot(wd); // (R22)
   wire e_cmd = wr_cmd & ~err_reg & (~s_addr | ~fcs_code_ok(wd) | cmd_sec); // (R18) (R20)
   wire take_cmd = wr_cmd & ~err_reg & ~e_cmd; // (R7) (R8)
   wire e_div = wr_div & ~err_reg & ~s_idle; // (R19)
   wire load_div = wr_div & ~err_reg & ~div_ld_reg & s_idle; // (R2) (R3)
   wire e_stat = wr_stat & ~err_reg & (s_addr | (s_cmd & ~wd[7])); // (R10) (R19)
   wire launch = wr_stat & ~err_reg & s_cmd & wd[7]; // (R9)
   wire err_clr = wr_stat & wd[`FCS_ST_ERR_BIT]; // (R15)
   wire running = (ex_reg == FCS_EX_PROG) || (ex_reg == FCS_EX_ERASE);
   wire e_stop = stop_req & running; // (R21)
   wire err_set = e_arr | e_cmd | e_div | e_stat | e_stop;

   // Timing clock tick from bus clock, optional divide by eight first
   wire [8:0] pre_lim = div_pre_reg ? {div_val_reg, 3'b111} : {3'b000, div_val_reg};
   wire tick = div_ld_reg & (pre_cnt_reg == pre_lim);

   // Executor completion and hand-over of the queued command
   wire cnt_end = (ex_cnt_reg == 15'h0001) & tick;
   wire blank_end = (ex_reg == FCS_EX_BLANK) & (ex_cnt_reg[AW-1:0] == AW'(ARRAY_BYTES - 1));
   wire ex_done = (running & cnt_end) | blank_end;
   wire queued = ~cbef_reg;
   wire ex_free = (ex_reg == FCS_EX_IDLE) | ex_done;
   wire take = queued & ex_free & ~e_stop; // (R23)
   wire nxt_burst = (buf_cmd_reg == `FCS_CMD_BURST);
   wire same_row = (buf_addr_reg[AW-1:RB] == ex_addr_reg[AW-1:RB]);
   wire new_row = (buf_addr_reg[RB-1:0] == '0);
   // Chain only when the queued burst byte continues the same row
   wire chain = (ex_reg == FCS_EX_PROG) & ex_burst_reg & nxt_burst & same_row & ~new_row; // (R12)
   wire cur_blank = (ex_reg == FCS_EX_BLANK) & (mem[ex_cnt_reg[AW-1:0]] != `FCS_ERASED);

   // Executor next state and load value
   always_comb
   begin
      ex_next = ex_reg;
      ex_cnt_next = ex_cnt_reg;
      if (e_stop)
      begin
         ex_next = FCS_EX_IDLE; // (R21)
      end
      else if (take)
      begin
         case (buf_cmd_reg)
            `FCS_CMD_BLANK:
            begin
               ex_next = FCS_EX_BLANK;
               ex_cnt_next = '0;
            end
            `FCS_CMD_PAGE:
            begin
               ex_next = FCS_EX_ERASE;
               ex_cnt_next = 15'(PAGE_TICKS); // (R4)
            end
            `FCS_CMD_MASS:
            begin
               ex_next = FCS_EX_ERASE;
               ex_cnt_next = 15'(MASS_TICKS); // (R4)
            end
            default:
            begin
               ex_next = FCS_EX_PROG;
               ex_cnt_next = chain ? `FCS_T_BURST : `FCS_T_BYTE; // (R4) (R13)
            end
         endcase
      end
      else if (ex_done)
      begin
         ex_next = FCS_EX_IDLE;
      end
      else if (ex_reg == FCS_EX_BLANK)
      begin
         ex_cnt_next = ex_cnt_reg + 15'h0001;
      end
      else if (running & tick)
      begin
         ex_cnt_next = ex_cnt_reg - 15'h0001;
      end
   end

   // Sequence tracker; any error drops the partial sequence
   always_comb
   begin
      seq_next = seq_reg;
      if (err_set)
      begin
         seq_next = FCS_SEQ_IDLE; // (R10)
      end
      else if (start)
      begin
         seq_next = FCS_SEQ_ADDR;
      end
      else if (take_cmd)
      begin
         seq_next = FCS_SEQ_CMD;
      end
      else if (launch)
      begin
         seq_next = FCS_SEQ_IDLE;
      end
   end

   // Bus data phase capture and registered read data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_reg <= 1'b0;
         dp_bdm_reg <= 1'b0;
         dp_addr_reg <= '0;
         hrdata_reg <= '0;
      end
      else if (hce)
      begin
         dp_wr_reg <= addr_take & hwrite;
         dp_bdm_reg <= bdm_access;
         if (addr_take)
         begin
            dp_addr_reg <= haddr;
         end
         if (addr_take & ~hwrite)
         begin
            hrdata_reg <= rd_word;
         end
      end
   end

   // Divider and access error flag; a new error beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_val_reg <= `FCS_DIV_RESET;
         div_pre_reg <= 1'b0;
         div_ld_reg <= 1'b0;
         err_reg <= 1'b0;
         pre_cnt_reg <= '0;
      end
      else if (hce)
      begin
         if (load_div)
         begin
            div_val_reg <= wd[5:0]; // (R2)
            div_pre_reg <= wd[`FCS_DIV_PRE_BIT];
            div_ld_reg <= 1'b1;
         end
         err_reg <= err_set | (err_reg & ~err_clr); // (R15)
         pre_cnt_reg <= (tick | ~div_ld_reg) ? 9'h000 : pre_cnt_reg + 9'h001;
      end
   end

   // Command buffer: captured address, data and code
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         seq_reg <= FCS_SEQ_IDLE;
         buf_addr_reg <= '0;
         buf_data_reg <= '0;
         buf_cmd_reg <= '0;
         cbef_reg <= 1'b1;
      end
      else if (hce)
      begin
         seq_reg <= seq_next;
         if (start)
         begin
            buf_addr_reg <= dp_idx; // (R5)
            buf_data_reg <= wd;
         end
         if (take_cmd)
         begin
            buf_cmd_reg <= wd; // (R7) (R8)
         end
         // Launch empties the flag; handing over or a stop abort refills it
         if (launch)
         begin
            cbef_reg <= 1'b0; // (R9)
         end
         else if (take | (e_stop & queued))
         begin
            cbef_reg <= 1'b1; // (R23)
         end
      end
   end

   // Executor state, pump control and blank result
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ex_reg <= FCS_EX_IDLE;
         ex_cnt_reg <= '0;
         ex_addr_reg <= '0;
         ex_data_reg <= '0;
         ex_burst_reg <= 1'b0;
         ex_mass_reg <= 1'b0;
         pump_reg <= 1'b0;
         blank_reg <= 1'b0;
      end
      else if (hce)
      begin
         ex_reg <= ex_next;
         ex_cnt_reg <= ex_cnt_next;
         if (take)
         begin
            ex_addr_reg <= buf_addr_reg;
            ex_data_reg <= buf_data_reg;
            ex_burst_reg <= nxt_burst;
            ex_mass_reg <= (buf_cmd_reg == `FCS_CMD_MASS);
         end
         // Pump is on for program and erase; kept across only a chained burst
         if (e_stop)
         begin
            pump_reg <= 1'b0; // (R21)
         end
         else if (take)
         begin
            // An unchained hand-over drops the pump for one cycle first
            pump_reg <= (buf_cmd_reg != `FCS_CMD_BLANK) & (~ex_done | chain); // (R13)
         end
         else if (running | ex_done)
         begin
            pump_reg <= ~ex_done; // (R14)
         end
         // Blank result built up over the scan
         if (take & (buf_cmd_reg == `FCS_CMD_BLANK))
         begin
            blank_reg <= 1'b1;
         end
         else if (cur_blank)
         begin
            blank_reg <= 1'b0;
         end
      end
   end

   // Array contents change only when an operation finishes; no reset on storage
   always_ff @(posedge hclk)
   begin
      if (hce & running & cnt_end & ~stop_req)
      begin
         if (ex_reg == FCS_EX_PROG)
         begin
            mem[ex_addr_reg] <= mem[ex_addr_reg] & ex_data_reg; // (R6)
         end
         else if (ex_mass_reg)
         begin
            for (int i = 0; i < ARRAY_BYTES; i++)
            begin
               mem[i] <= `FCS_ERASED; // (R8)
            end
         end
         else
         begin
            for (int i = 0; i < (1 << PB); i++)
            begin
               mem[{ex_addr_reg[AW-1:PB], PB'(i)}] <= `FCS_ERASED; // (R6)
            end
         end
      end
   end

   // Outputs; stall the bus while frozen so no transfer is lost
   assign hreadyout = hce;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign pump_on = pump_reg;
   assign flash_busy = (ex_reg != FCS_EX_IDLE) | queued; // (R11)

endmodule : fcs_flash_sequencer

// [verif/fcs_flash_sequencer_assertions.sv]
// Port checker for the flash command sequencer
`timescale 1ns/1ps
module fcs_flash_sequencer_assertions (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hce,
   // Bus slave side
   input wire logic hsel,
   input wire logic [17:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // System status and array outputs
   input wire logic bdm_access,
   input wire logic secured,
   input wire logic stop_req,
   input wire logic pump_on,
   input wire logic flash_busy
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // A read accepted in its address phase
   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite && hce;
   endsequence
   // Busy span in cycles; a delay range cannot reach two queued erases at the bench divider
   localparam int BUSY_LIMIT = 6000;
   logic [12:0] busy_cnt_reg;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy_cnt_reg <= '0;
      end
      else if (!flash_busy)
      begin
         busy_cnt_reg <= '0;
      end
      else if (hce && busy_cnt_reg != 13'h1fff)
      begin
         busy_cnt_reg <= busy_cnt_reg + 13'h0001;
      end
   end
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("slave answered with an error response");
   ready_follows_a: assert property (hreadyout == hce)
      else $error("ready does not follow the clock enable");
   read_upper_a: assert property (s_rd |=> hrdata[31:8] == 24'h0)
      else $error("read data has upper bits set");
   read_holds_a: assert property (!s_rd |=> $stable(hrdata))
      else $error("read data changed without a read");
   pump_busy_a: assert property (pump_on |-> flash_busy)
      else $error("pump on while the sequencer is idle");
   pump_cause_a: assert property ($rose(pump_on) |-> $past(flash_busy))
      else $error("pump started without a launched command");
   busy_ends_a: assert property (busy_cnt_reg <= 13'(BUSY_LIMIT))
      else $error("command never completed");
   stop_abort_a: assert property (stop_req && pump_on |-> ##[1:3] !pump_on)
      else $error("stop did not abort the running operation");
   reset_vals_a: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !flash_busy)
      else $error("outputs not at reset values");
endmodule : fcs_flash_sequencer_assertions
bind fcs_flash_sequencer fcs_flash_sequencer_assertions chk (.*);

// [verif/fcs_bus_master.sv]
// Bus master model standing in for the processor or the debug controller
`timescale 1ns/1ps
module fcs_bus_master (
   // Clock and slave answer
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Request
   output logic hsel,
   output logic [17:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // Idle bus until the first transfer
   initial
   begin
      hsel = 1'b0;
      haddr = 18'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // One word transfer; caller enters just after a rising edge
   task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      // Released data inverted so a stale value is never mistaken for fresh
      hwdata <= ~d;
   endtask : xfer
endmodule : fcs_bus_master

// [verif/test_flash_command_sequencer.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "fcs_map.svh"
module test_flash_command_sequencer;
   localparam logic [17:0] DIV = `FCS_DIV_OFF;
   localparam logic [17:0] ST = `FCS_STAT_OFF;
   localparam logic [17:0] CMD = `FCS_CMD_OFF;
   // Prescale by eight, divide by 13: 104 bus cycles, about 192 kHz timing clock
   localparam logic [31:0] DIV_CFG = 32'h0000004c;
   localparam int TP = 104;
   logic hclk, hresetn, hce, bdm_access, secured, stop_req;
   logic hsel, hwrite, hreadyout, hresp, pump_on, flash_busy;
   logic [17:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   wire logic hready = hreadyout;
   int fail_count = 0;
   int num_checks = 0;
   // Short erase counts and a small array keep the run brief
   fcs_flash_sequencer #(.ARRAY_BYTES(1024), .PAGE_TICKS(10), .MASS_TICKS(20)) dut (
      .hclk, .hresetn, .hce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .bdm_access, .secured, .stop_req,
      .pump_on, .flash_busy);
   fcs_bus_master bus (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata);
   // Clock
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus.xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rdchk(input logic [17:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus.xfer(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask : rdchk
   function automatic logic [17:0] arr(input int i);
      return 18'h20000 + 18'(i * 4);
   endfunction : arr
   task automatic seq(input int i, input logic [7:0] d, input logic [7:0] c);
      wr(arr(i), {24'h0, d});
      wr(CMD, {24'h0, c});
      wr(ST, 32'h80);
   endtask : seq
   // Waits out the job, counting cycles and pump drops while work remains
   task automatic wait_done(output int n, output int pf);
      logic p;
      n = 0;
      pf = 0;
      #1;
      p = pump_on;
      while (flash_busy === 1'b1 && n < 5000)
      begin
         @(posedge hclk);
         #1;
         n++;
         if (p === 1'b1 && pump_on === 1'b0 && flash_busy === 1'b1)
            pf++;
         p = pump_on;
      end
      @(posedge hclk);
   endtask : wait_done
   task automatic t_setup();
      rdchk(DIV, 32'h0);
      rdchk(ST, 32'hc0);
      wr(arr(0), 32'h0);
      rdchk(ST, 32'hd0);
      wr(DIV, 32'h0);
      rdchk(DIV, 32'h0);
      wr(ST, 32'h10);
      rdchk(ST, 32'hc0);
      wr(DIV, DIV_CFG);
      wr(DIV, 32'h3f);
      rdchk(DIV, 32'hcc);
   endtask : t_setup
   task automatic t_program();
      int n, pf;
      seq(5, 8'h00, `FCS_CMD_MASS);
      wait_done(n, pf);
      chk(32'(n >= 19 * TP + 2 && n <= 20 * TP + 1), 32'h1);
      seq(900, 8'h3c, `FCS_CMD_BLANK);
      wait_done(n, pf);
      rdchk(ST, 32'hc4);
      seq(3, 8'h5a, `FCS_CMD_BYTE);
      wait_done(n, pf);
      chk(32'(n >= 8 * TP + 2 && n <= 9 * TP + 1), 32'h1);
      rdchk(arr(3), 32'h5a);
      seq(0, 8'h00, `FCS_CMD_BLANK);
      wait_done(n, pf);
      rdchk(ST, 32'hc0);
      seq(500, 8'h77, `FCS_CMD_PAGE);
      wait_done(n, pf);
      chk(32'(n >= 9 * TP + 2 && n <= 10 * TP + 1), 32'h1);
      rdchk(arr(3), 32'hff);
   endtask : t_program
   task automatic t_errors();
      int n, pf;
      for (int k = 0; k < 7; k++)
      begin
         bdm_access <= (k == 6);
         secured <= (k == 6);
         wr(arr(10), 32'h0);
         case (k)
            0: wr(CMD, 32'h33);
            1: wr(ST, 32'h0);
            2: wr(arr(11), 32'h0);
            3: wr(DIV, 32'h0);
            4:
            begin
               // Second erase queues behind the first, so the buffer stays occupied
               wr(CMD, {24'h0, `FCS_CMD_MASS});
               wr(ST, 32'h80);
               seq(11, 8'h00, `FCS_CMD_MASS);
               wr(arr(13), 32'h0);
               wait_done(n, pf);
            end
            5: wr(ST, 32'h80);
            default: wr(CMD, {24'h0, `FCS_CMD_BYTE});
         endcase
         rdchk(ST, 32'hd0);
         seq(12, 8'h00, `FCS_CMD_BYTE);
         wr(ST, 32'h10);
         rdchk(ST, 32'hc0);
         rdchk(arr(12), 32'hff);
      end
      seq(0, 8'h00, `FCS_CMD_MASS);
      wait_done(n, pf);
      rdchk(ST, 32'hc0);
      bdm_access <= 1'b0;
      secured <= 1'b0;
   endtask : t_errors
   task automatic t_burst();
      int n, pf;
      seq(128, 8'h11, `FCS_CMD_BURST);
      @(posedge hclk);
      seq(129, 8'h22, `FCS_CMD_BURST);
      wait_done(n, pf);
      chk(32'(pf), 32'h0);
      chk({31'h0, pump_on}, 32'h0);
      rdchk(arr(129), 32'h22);
      seq(191, 8'h33, `FCS_CMD_BURST);
      @(posedge hclk);
      seq(192, 8'h44, `FCS_CMD_BURST);
      wait_done(n, pf);
      chk(32'(pf), 32'h1);
      rdchk(arr(192), 32'h44);
   endtask : t_burst
   task automatic t_stop();
      seq(600, 8'h00, `FCS_CMD_PAGE);
      repeat (3) @(posedge hclk);
      stop_req <= 1'b1;
      repeat (3) @(posedge hclk);
      stop_req <= 1'b0;
      rdchk(ST, 32'hd0);
      chk({31'h0, flash_busy}, 32'h0);
      wr(ST, 32'h10);
   endtask : t_stop
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      hce = 1'b1;
      bdm_access = 1'b0;
      secured = 1'b0;
      stop_req = 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_setup();
      t_program();
      t_errors();
      t_burst();
      t_stop();
      print_verdict();
   end
   // Watchdog: the whole run needs less than half of this
   initial
   begin
      repeat (40000) @(posedge hclk);
      fail_count++;
      print_verdict();
   end
endmodule : test_flash_command_sequencer
